// ---- design/tx_slip_buffer_interrupt_enable.sv ----
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/100ps

module tx_slip_buffer_interrupt_enable (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire tx_slip_pkg::reg_req_t     regReq,
  output logic [7:0]                     regRdData,
  input  wire tx_slip_pkg::byte_strm_t   sysByte,
  input  wire logic                      lineRdReq,
  output tx_slip_pkg::byte_strm_t        lineByte,
  output logic                           irqOut
);

  // ==========================================================================
  // Address decoding.
  function automatic logic regHit(input logic [7:0] addr, input logic [7:0] ofs);
    regHit = (addr == ofs);
  endfunction : regHit

  wire        statusRd  = regReq.rd && regHit(regReq.addr, tx_slip_pkg::STATUS_OFS);
  wire        enableRd  = regReq.rd && regHit(regReq.addr, tx_slip_pkg::ENABLE_OFS);
  wire        enableWr  = regReq.wr && regHit(regReq.addr, tx_slip_pkg::ENABLE_OFS);
  wire        clearWr   = regReq.wr && regHit(regReq.addr, tx_slip_pkg::CLEAR_OFS);

  // ==========================================================================
  // Registers and slip buffer.
  logic [7:0]               enable_ff;
  logic [7:0]               status_ff;
  logic [7:0]               regRdData_ff;
  logic                     irq_ff;
  tx_slip_pkg::byte_strm_t  lineByte_ff;
  logic [7:0]               nxt_enable;
  logic [7:0]               nxt_status;
  logic [7:0]               nxt_rdData;
  logic [7:0]               storeByte;
  logic                     frameDrop;
  logic                     frameRepeat;
  logic [2:0]               events;

  tx_slip_store u_store (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .ce          (ce),
    .wrByte      (sysByte),
    .rdReq       (lineRdReq),
    .rdByte      (storeByte),
    .frameDrop   (frameDrop),
    .frameRepeat (frameRepeat)
  );

  // Events in status order: slip, underflow, overflow.
  assign events = {frameDrop, frameRepeat, frameDrop || frameRepeat};

  assign nxt_enable = enableWr ? (regReq.wdata & tx_slip_pkg::EVENT_MASK) : enable_ff;

  // Sticky status: a new event beats a clearing read or write in the same cycle.
  genvar i;
  for (i = 0; i < 8; i++) begin : g_status
    if (i >= tx_slip_pkg::EVENT_LSB && i < tx_slip_pkg::EVENT_LSB + tx_slip_pkg::EVENT_N) begin : g_evt
      assign nxt_status[i] = events[i - tx_slip_pkg::EVENT_LSB] ||
                             (status_ff[i] && !statusRd && !(clearWr && regReq.wdata[i]));
    end else begin : g_rsv
      assign nxt_status[i] = 1'b0;
    end
  end

  assign nxt_rdData = statusRd ? status_ff :
                      enableRd ? enable_ff : tx_slip_pkg::REG_RESET;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enable_ff    <= tx_slip_pkg::REG_RESET;
      status_ff    <= tx_slip_pkg::REG_RESET;
      regRdData_ff <= tx_slip_pkg::REG_RESET;
      irq_ff       <= 1'b0;
      lineByte_ff  <= '0;
    end else if (ce) begin
      enable_ff    <= nxt_enable;
      status_ff    <= nxt_status;
      regRdData_ff <= nxt_rdData;
      irq_ff       <= |(nxt_status & nxt_enable);
      lineByte_ff  <= '{valid: lineRdReq, data: storeByte};
    end
  end

  assign regRdData = regRdData_ff;
  assign irqOut    = irq_ff;
  assign lineByte  = lineByte_ff;

  // ==========================================================================
  // Checks.
  chk_overflow_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
    ce && status_ff[7] && enable_ff[7] && !statusRd && !clearWr && !enableWr |=> irqOut)
    else $error("Enabled overflow status did not raise the interrupt.");

  chk_overflow_status: assert property (@(posedge sys_clk) disable iff (rst)
    ce && sysByte.valid && !lineRdReq && frameDrop |=> status_ff[7] && status_ff[5])
    else $error("Overflow drop did not set status.");

  chk_underflow_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !enableWr && enable_ff[7:5] == 3'h2 |=> irqOut == status_ff[6])
    else $error("Underflow interrupt does not follow its status bit alone.");

  chk_underflow_status: assert property (@(posedge sys_clk) disable iff (rst)
    ce && lineRdReq && frameRepeat |=> status_ff[6] && status_ff[5] && lineByte.valid)
    else $error("Underflow repeat did not set status.");

  chk_slip_irq: assert property (@(posedge sys_clk) disable iff (rst)
    ce && enable_ff[5] && !enableWr && (frameDrop || frameRepeat) |=> irqOut)
    else $error("Slip event did not raise the enabled interrupt.");

  chk_status_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !statusRd && !clearWr |=> (status_ff & $past(status_ff)) == $past(status_ff))
    else $error("Status bit dropped without a read.");

  chk_status_read_clear: assert property (@(posedge sys_clk) disable iff (rst)
    ce && statusRd && events == 3'h0 |=> status_ff == 8'h00 ##0 regRdData == $past(status_ff))
    else $error("Status read did not return and clear the bits.");

  chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
    ce && enableRd |=> regRdData[4:0] == 5'h00)
    else $error("Reserved enable bits read nonzero.");

  // ==========================================================================
  // Interrupt gating, register map, clock enable and stream checks.
  chk_irq_level_match: assert property (@(posedge sys_clk) disable iff (rst)
    irqOut == |(status_ff & enable_ff))
    else $error("Interrupt level differs from enabled status.");

  chk_overflow_irq_mask: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !enableWr && enable_ff[7:5] == 3'h4 |=> irqOut == status_ff[7])
    else $error("Overflow interrupt does not follow its status bit alone.");

  chk_slip_irq_mask: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !enableWr && enable_ff[7:5] == 3'h1 |=> irqOut == status_ff[5])
    else $error("Slip interrupt does not follow its status bit alone.");

  chk_irq_low_disabled: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !enableWr && enable_ff[7:5] == 3'h0 |=> !irqOut)
    else $error("Interrupt raised with every enable off.");

  chk_overflow_no_unf: assert property (@(posedge sys_clk) disable iff (rst)
    ce && frameDrop && !status_ff[6] |=> !status_ff[6])
    else $error("Overflow drop set the underflow status.");

  chk_underflow_no_ovf: assert property (@(posedge sys_clk) disable iff (rst)
    ce && frameRepeat && !status_ff[7] |=> !status_ff[7])
    else $error("Underflow repeat set the overflow status.");

  chk_slip_with_event: assert property (@(posedge sys_clk) disable iff (rst)
    ce && (frameDrop || frameRepeat) |=> status_ff[5])
    else $error("Slip event did not set the slip status.");

  chk_status_no_event: assert property (@(posedge sys_clk) disable iff (rst)
    ce && events == 3'h0 |=> (status_ff & ~$past(status_ff)) == 8'h00)
    else $error("Status bit set without a slip event.");

  chk_enable_write: assert property (@(posedge sys_clk) disable iff (rst)
    ce && enableWr |=> enable_ff == ($past(regReq.wdata) & tx_slip_pkg::EVENT_MASK))
    else $error("Enable write did not land as masked.");

  chk_enable_hold: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !enableWr |=> enable_ff == $past(enable_ff))
    else $error("Enable register changed without a write.");

  chk_enable_rsv_zero: assert property (@(posedge sys_clk) disable iff (rst)
    enable_ff[4:0] == 5'h00)
    else $error("Reserved enable bits hold a one.");

  chk_clear_write: assert property (@(posedge sys_clk) disable iff (rst)
    ce && clearWr && events == 3'h0 |=> (status_ff & $past(regReq.wdata)) == 8'h00)
    else $error("Clear write left a status bit set.");

  chk_status_read_data: assert property (@(posedge sys_clk) disable iff (rst)
    ce && statusRd |=> regRdData == $past(status_ff))
    else $error("Status read returned the wrong value.");

  chk_enable_read: assert property (@(posedge sys_clk) disable iff (rst)
    ce && enableRd |=> regRdData == $past(enable_ff))
    else $error("Enable read returned the wrong value.");

  chk_rddata_idle: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !regReq.rd |=> regRdData == 8'h00)
    else $error("Read data nonzero without a read.");

  chk_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst)
    ce && regReq.rd && !statusRd && !enableRd |=> regRdData == 8'h00)
    else $error("Unmapped read returned nonzero data.");

  chk_line_valid: assert property (@(posedge sys_clk) disable iff (rst)
    ce |=> lineByte.valid == $past(lineRdReq))
    else $error("Line byte valid does not follow the read request.");

  chk_freeze_status: assert property (@(posedge sys_clk) disable iff (rst)
    !ce |=> status_ff == $past(status_ff))
    else $error("Status changed while the clock enable was low.");

  chk_freeze_enable: assert property (@(posedge sys_clk) disable iff (rst)
    !ce |=> enable_ff == $past(enable_ff))
    else $error("Enable changed while the clock enable was low.");

  chk_freeze_irq: assert property (@(posedge sys_clk) disable iff (rst)
    !ce |=> irqOut == $past(irqOut))
    else $error("Interrupt changed while the clock enable was low.");

  chk_freeze_rddata: assert property (@(posedge sys_clk) disable iff (rst)
    !ce |=> regRdData == $past(regRdData))
    else $error("Read data changed while the clock enable was low.");

  chk_freeze_line: assert property (@(posedge sys_clk) disable iff (rst)
    !ce |=> lineByte == $past(lineByte))
    else $error("Line byte changed while the clock enable was low.");

endmodule : tx_slip_buffer_interrupt_enable

// ---- shared/tx_slip_pkg.sv ----
package tx_slip_pkg;

  // ==========================================================================
  // Sizes of the slip buffer.
  localparam int           DATA_W      = 8;
  localparam int           ADDR_W      = 8;
  localparam int           PTR_W       = 6;
  localparam int           CNT_W       = 7;
  localparam int           BUF_BYTES   = 64;
  localparam logic [5:0]   FRAME_PTR   = 6'h20;
  localparam logic [6:0]   FRAME_CNT   = 7'h20;
  localparam logic [6:0]   FULL_CNT    = 7'h40;
  localparam logic [6:0]   CNT_RESET   = 7'h00;
  localparam logic [5:0]   PTR_RESET   = 6'h00;

  // ==========================================================================
  // Register offsets and field positions.
  localparam logic [7:0]   STATUS_OFS  = 8'h08;
  localparam logic [7:0]   ENABLE_OFS  = 8'h09;
  localparam logic [7:0]   CLEAR_OFS   = 8'h0C;
  localparam int           SLIP_BIT    = 5;
  localparam int           UNF_BIT     = 6;
  localparam int           OVF_BIT     = 7;
  localparam int           EVENT_LSB   = 5;
  localparam int           EVENT_N     = 3;
  localparam logic [7:0]   EVENT_MASK  = 8'hE0;
  localparam logic [7:0]   REG_RESET   = 8'h00;

  // ==========================================================================
  // Carriers.
  typedef struct packed {
    logic             valid;
    logic [7:0]       data;
  } byte_strm_t;

  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [7:0]       addr;
    logic [7:0]       wdata;
  } reg_req_t;

endpackage : tx_slip_pkg

// ---- design/tx_slip_store.sv ----
`timescale 1ns/100ps

module tx_slip_store (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire tx_slip_pkg::byte_strm_t   wrByte,
  input  wire logic                      rdReq,
  output logic [7:0]                     rdByte,
  output logic                           frameDrop,
  output logic                           frameRepeat
);

  // ==========================================================================
  // Storage and pointers.
  logic [7:0] mem [tx_slip_pkg::BUF_BYTES];
  logic [5:0] wrPtr_ff;
  logic [5:0] rdPtr_ff;
  logic [6:0] count_ff;
  logic [5:0] nxt_wrPtr;
  logic [5:0] nxt_rdPtr;
  logic [6:0] nxt_count;
  logic [5:0] rdBase;
  logic [6:0] wrInc;
  logic [6:0] rdDec;
  logic [6:0] dropAmt;
  logic [6:0] repAmt;
  wire        isFull  = (count_ff == tx_slip_pkg::FULL_CNT);
  wire        isEmpty = (count_ff == tx_slip_pkg::CNT_RESET);

  // ==========================================================================
  // Slip decisions and next pointers.
  assign frameDrop   = wrByte.valid && isFull && !rdReq;
  assign frameRepeat = rdReq && isEmpty;
  assign rdBase      = (frameDrop || frameRepeat) ? rdPtr_ff + tx_slip_pkg::FRAME_PTR : rdPtr_ff;
  assign rdByte      = mem[rdBase];
  assign wrInc       = {6'h00, wrByte.valid};
  assign rdDec       = {6'h00, rdReq};
  assign dropAmt     = frameDrop ? tx_slip_pkg::FRAME_CNT : tx_slip_pkg::CNT_RESET;
  assign repAmt      = frameRepeat ? tx_slip_pkg::FRAME_CNT : tx_slip_pkg::CNT_RESET;
  assign nxt_count   = count_ff + wrInc - rdDec - dropAmt + repAmt;
  assign nxt_rdPtr   = rdBase + {5'h00, rdReq};
  assign nxt_wrPtr   = wrPtr_ff + {5'h00, wrByte.valid};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr_ff <= tx_slip_pkg::PTR_RESET;
      rdPtr_ff <= tx_slip_pkg::PTR_RESET;
      count_ff <= tx_slip_pkg::CNT_RESET;
    end else if (ce) begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce && wrByte.valid) begin
      mem[wrPtr_ff] <= wrByte.data;
    end
  end

  // ==========================================================================
  // Checks.
  chk_drop_frame: assert property (@(posedge sys_clk) disable iff (rst)
    ce && frameDrop |=> count_ff == 7'h21 && rdPtr_ff == $past(rdPtr_ff) + 6'h20)
    else $error("Overflow write did not drop one frame.");

  chk_repeat_frame: assert property (@(posedge sys_clk) disable iff (rst)
    ce && frameRepeat && !wrByte.valid |=> count_ff == 7'h1F && rdPtr_ff == $past(rdPtr_ff) + 6'h21)
    else $error("Underflow read did not repeat one frame.");

  chk_count_bound: assert property (@(posedge sys_clk) disable iff (rst)
    count_ff <= tx_slip_pkg::FULL_CNT)
    else $error("Fill count exceeds two frames.");

endmodule : tx_slip_store

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps

module tb_top;

  // ==========================================================================
  // Clock, reset and the block.
  logic                    sys_clk     = 1'b0;
  logic                    rst         = 1'b1;
  logic                    ce          = 1'b1;
  tx_slip_pkg::reg_req_t   regReq      = '0;
  tx_slip_pkg::byte_strm_t sysByte     = '0;
  logic                    lineRdReq   = 1'b0;
  logic [7:0]              regRdData;
  tx_slip_pkg::byte_strm_t lineByte;
  logic                    irqOut;
  int                      miscompares = 0;
  int                      nTests      = 0;

  always #5 sys_clk = ~sys_clk;

  tx_slip_buffer_interrupt_enable tx_slip_buffer_interrupt_enable_i (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .regReq(regReq), .regRdData(regRdData),
    .sysByte(sysByte), .lineRdReq(lineRdReq), .lineByte(lineByte), .irqOut(irqOut));

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    regReq.wr <= 1'b0;
    #1;
  endtask : reg_wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    regReq.rd <= 1'b0;
    #1;
    chk(what, regRdData, exp);
  endtask : rd_chk

  task automatic push_n(input int n, input int base);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      sysByte <= '{valid: 1'b1, data: 8'(base + i)};
    end
    @(posedge sys_clk);
    sysByte.valid <= 1'b0;
    #1;
  endtask : push_n

  task automatic pull_chk(input logic [7:0] exp);
    @(posedge sys_clk);
    lineRdReq <= 1'b1;
    @(posedge sys_clk);
    lineRdReq <= 1'b0;
    #1;
    chk("line valid", {7'h00, lineByte.valid}, 8'h01);
    chk("line data", lineByte.data, exp);
  endtask : pull_chk

  // ==========================================================================
  // Scenarios.
  task automatic test_reset;
    rd_chk(tx_slip_pkg::ENABLE_OFS, tx_slip_pkg::REG_RESET, "enable reset");
    rd_chk(tx_slip_pkg::STATUS_OFS, 8'h00, "status reset");
    rd_chk(8'h3F, 8'h00, "unmapped read");
    chk("irq reset", {7'h00, irqOut}, 8'h00);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_enable;
    @(posedge sys_clk);
    ce <= 1'b0;
    reg_wr(tx_slip_pkg::ENABLE_OFS, 8'hFF);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd_chk(tx_slip_pkg::ENABLE_OFS, 8'h00, "enable frozen");
    reg_wr(tx_slip_pkg::ENABLE_OFS, 8'hFF);
    rd_chk(tx_slip_pkg::ENABLE_OFS, 8'hE0, "enable bits");
    $display("test_enable done");
  endtask : test_enable

  task automatic test_overflow;
    reg_wr(tx_slip_pkg::ENABLE_OFS, 8'h80);
    push_n(64, 0);
    chk("irq when full", {7'h00, irqOut}, 8'h00);
    rd_chk(tx_slip_pkg::STATUS_OFS, 8'h00, "status full");
    push_n(1, 64);
    chk("irq overflow", {7'h00, irqOut}, 8'h01);
    reg_wr(tx_slip_pkg::ENABLE_OFS, 8'h00);
    chk("irq masked", {7'h00, irqOut}, 8'h00);
    rd_chk(tx_slip_pkg::STATUS_OFS, 8'hA0, "status overflow");
    rd_chk(tx_slip_pkg::STATUS_OFS, 8'h00, "status cleared");
    for (int i = 0; i < 33; i++) pull_chk(8'(32 + i));
    $display("test_overflow done");
  endtask : test_overflow

  task automatic test_underflow;
    reg_wr(tx_slip_pkg::ENABLE_OFS, 8'h40);
    pull_chk(8'h21);
    chk("irq underflow", {7'h00, irqOut}, 8'h01);
    pull_chk(8'h22);
    reg_wr(tx_slip_pkg::CLEAR_OFS, 8'h40);
    chk("irq cleared", {7'h00, irqOut}, 8'h00);
    reg_wr(tx_slip_pkg::ENABLE_OFS, 8'h20);
    chk("irq slip", {7'h00, irqOut}, 8'h01);
    rd_chk(tx_slip_pkg::STATUS_OFS, 8'h20, "status slip");
    chk("irq after read", {7'h00, irqOut}, 8'h00);
    $display("test_underflow done");
  endtask : test_underflow

  task automatic test_slip;
    reg_wr(tx_slip_pkg::ENABLE_OFS, 8'h80);
    for (int i = 0; i < 30; i++) pull_chk(8'(35 + i));
    pull_chk(8'h21);
    chk("irq empty gated", {7'h00, irqOut}, 8'h00);
    rd_chk(tx_slip_pkg::STATUS_OFS, 8'h60, "status underflow");
    reg_wr(tx_slip_pkg::ENABLE_OFS, 8'h20);
    push_n(34, 100);
    chk("irq slip drop", {7'h00, irqOut}, 8'h01);
    rd_chk(tx_slip_pkg::STATUS_OFS, 8'hA0, "status drop");
    chk("irq slip read", {7'h00, irqOut}, 8'h00);
    $display("test_slip done");
  endtask : test_slip

  // ==========================================================================
  // Verdict and run control.
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset;
    test_enable;
    test_overflow;
    test_underflow;
    test_slip;
    close_out;
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    close_out;
  end

endmodule : tb_top
